// [core/pmr_consts.svh]
`ifndef PMR_CONSTS_SVH
`define PMR_CONSTS_SVH

// ----------------------------------------
// Register offsets on the management link
// ----------------------------------------
`define PMR_REG_EXPANSION 5'h06
`define PMR_REG_MODE_CS 5'h11
`define PMR_REG_SPECIAL_MODES 5'h12
`define PMR_REG_CROSSOVER 5'h1b
`define PMR_REG_IRQ_FLAGS 5'h1d
`define PMR_REG_IRQ_MASK 5'h1e

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PMR_EXP_PD_FAULT 4
`define PMR_EXP_LP_NP 3
`define PMR_EXP_PAGE_RX 1
`define PMR_EXP_LP_AN 0
`define PMR_MCS_EDPD 13
`define PMR_MCS_ENERGY 1
`define PMR_XO_OVERRIDE 15
`define PMR_XO_AUTO 14
`define PMR_XO_STATE 13
`define PMR_XO_PLL_LOCK 10
`define PMR_XO_POLARITY 4

// ----------------------------------------
// Reset values and frame codes
// ----------------------------------------
`define PMR_MODE_RST 3'h7
`define PMR_PHY_MANAGEMENT_ADDRESS_RST 5'h01
`define PMR_OP_READ 2'h2
`define PMR_OP_WRITE 2'h1
`define PMR_PREAMBLE_LEN 6'h20

// ----------------------------------------
// Timing
// ----------------------------------------
`define PMR_SYS_CLK_KHZ 125000
`define PMR_ENERGY_TIMEOUT_MS 256
`define PMR_ENERGY_TIMEOUT_CYC (`PMR_ENERGY_TIMEOUT_MS * `PMR_SYS_CLK_KHZ)
`define PMR_ENERGY_CNT_W 25

`endif

// [core/pmr_pkg.sv]
package pmr_pkg;

	typedef enum logic [2:0] {
		SMI_IDLE,
		SMI_START,
		SMI_HDR,
		SMI_TA,
		SMI_DATA
	} pmr_smi_state_e;

	typedef struct packed {
		pmr_smi_state_e state;
		logic [5:0] pre_cnt;
		logic [4:0] bit_cnt;
		logic [15:0] shreg;
		logic [4:0] regad;
		logic is_rd;
		logic match;
		logic mdc_prev;
		logic mdio_o;
		logic mdio_oe;
		logic edpd;
		logic [2:0] mode;
		logic [4:0] phy_management_address;
		logic xo_ovr;
		logic xo_auto;
		logic xo_state;
		logic pll_lock;
		logic exp_pdf;
		logic exp_page;
		logic [7:1] isf;
		logic [7:0] imask;
		logic an_done_q;
		logic rfault_q;
		logic link_q;
		logic lp_ack_q;
		logic irq;
		logic [3:0] ctrl_def;
		logic [3:0] adv_def;
		logic an_en;
		logic crs_tx;
		logic repeater;
		logic xo_auto_en;
		logic xo_swap;
	} pmr_core_s;

	typedef struct packed {
		logic [3:0] meta;
		logic [3:0] sync;
	} pmr_sync_s;

	typedef struct packed {
		logic [24:0] cnt;
		logic flag;
	} pmr_timer_s;

endpackage

// [core/pmr_energy_if.sv]
`timescale 1ns/1ps

interface pmr_energy_if;
	logic energy_seen;
	logic flag;
	logic rise;

	modport timer (input energy_seen, output flag, output rise);
	modport core (output energy_seen, input flag, input rise);
endinterface

// [core/pmr_sync2.sv]
`timescale 1ns/1ps

module pmr_sync2 (
	// Clock and reset
	input logic clk_i,
	input logic rst_i,
	// Asynchronous levels in, synchronised levels out
	input logic [3:0] async_i,
	output logic [3:0] sync_o
);
	import pmr_pkg::*;

	pmr_sync_s st_ff;
	pmr_sync_s nxt_st;

	// First stage feeds only the second
	always_comb begin
		nxt_st = st_ff;
		nxt_st.meta = async_i;
		nxt_st.sync = st_ff.meta;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign sync_o = st_ff.sync;
endmodule

// [core/pmr_energy_timer.sv]
`timescale 1ns/1ps
`include "pmr_consts.svh"

module pmr_energy_timer #(
	parameter int TIMEOUT_CYC = `PMR_ENERGY_TIMEOUT_CYC
) (
	// Clock and hardware reset
	input logic clk_i,
	input logic rst_i,
	// Energy status toward the register core
	pmr_energy_if.timer ef
);
	import pmr_pkg::*;

	localparam logic [24:0] LIMIT = 25'(TIMEOUT_CYC - 1);

	pmr_timer_s st_ff;
	pmr_timer_s nxt_st;

	// Only hardware reset touches this; soft reset is not wired
	always_comb begin
		nxt_st = st_ff;
		if (ef.energy_seen) begin
			nxt_st.cnt = '0;
			nxt_st.flag = 1'b1;
		end else if (st_ff.cnt == LIMIT) begin
			nxt_st.flag = 1'b0;
		end else begin
			nxt_st.cnt = st_ff.cnt + 25'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff.cnt <= '0;
			st_ff.flag <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign ef.flag = st_ff.flag;
	assign ef.rise = ef.energy_seen & ~st_ff.flag;
endmodule

// [core/pmr_phy_mode_regs.sv]
`timescale 1ns/1ps
`include "pmr_consts.svh"

// Overview of operation
// - Expansion bit 4 latches parallel-detect fault
// - Expansion bit 1 latches page received
// - Bit 2 reads zero; bit 3 partner next-page
// - Bit 0 shows partner auto-negotiation ability
// - Bit 13 enables energy-detect power-down, resets zero
// - Energy flag drops after 256 ms quiet
// - Hardware reset sets energy flag; soft keeps
// - Mode field bits 7:5, resets 111, soft-immune
// - Bits 4:0 hold management address, default 00001
// - Modes 000/001 force 10 Mb/s, no negotiation
// - Modes 010/011 force 100 Mb/s, no negotiation
// - Modes 010/100 carrier sense on transmit too
// - Mode 100 negotiates, advertises 100 half only
// - Mode 101 repeater, carrier sense receive only
// - Mode 111 advertises all, follows negotiated result
// - Override clear: strap pin controls crossover
// - Override set: bit 14 enables auto crossover
// - Manual bit 13 swaps transmit and receive pairs
// - Bit 10 locks 10M PLL, soft-immune
// - Bit 4 reports 10BASE-T receive polarity
// - Flags 7,6,5: energy, negotiation done, remote fault
// - Flags 4..1: link down, ack, fault, page
// - Mask bits enable sources; all masked at reset
module pmr_phy_mode_regs #(
	parameter int ENERGY_TIMEOUT_CYC = `PMR_ENERGY_TIMEOUT_CYC
) (
	// Clock and resets
	input logic SYS_CLK_I,
	input logic RST_I,
	input logic SOFT_RST_I,
	// Serial management link
	input logic MDC_I,
	input logic MDIO_I,
	output logic MDIO_O,
	output logic MDIO_OE_O,
	// Pins from the line side
	input logic CROSSOVER_AUTO_STRAP_I,
	input logic LINE_ENERGY_I,
	// Status from the PHY core
	input logic PD_FAULT_I,
	input logic PAGE_RX_I,
	input logic LP_NEXT_PAGE_I,
	input logic LP_AUTONEG_I,
	input logic AUTONEG_DONE_I,
	input logic REMOTE_FAULT_I,
	input logic LINK_UP_I,
	input logic LP_ACK_I,
	input logic TENBASE_POLARITY_REVERSED_I,
	input logic RESOLVED_SPEED_100_I,
	input logic RESOLVED_FULL_DUPLEX_I,
	// Control toward the PHY core
	output logic PHY_IRQ_O,
	output logic ENERGY_DETECT_POWERDOWN_ENABLE_O,
	output logic ENERGY_PRESENT_FLAG_O,
	output logic [3:0] MODE_CTRL_DEFAULT_O,
	output logic [3:0] MODE_ADVERT_DEFAULT_O,
	output logic AUTONEG_ENABLE_O,
	output logic CRS_ON_TRANSMIT_O,
	output logic REPEATER_MODE_O,
	output logic CROSSOVER_AUTO_ENABLE_O,
	output logic CROSSOVER_SWAP_O,
	output logic RX_PLL_REFERENCE_LOCK_O
);
	import pmr_pkg::*;

	// ----------------------------------------
	// Pin synchronisers and energy timer
	// ----------------------------------------
	logic [3:0] pins_s;
	logic mdc_s;
	logic mdio_s;
	logic strap_s;

	pmr_energy_if ef();

	pmr_sync2 u_sync (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.async_i({LINE_ENERGY_I, CROSSOVER_AUTO_STRAP_I, MDIO_I, MDC_I}),
		.sync_o(pins_s)
	);

	assign mdc_s = pins_s[0];
	assign mdio_s = pins_s[1];
	assign strap_s = pins_s[2];
	assign ef.energy_seen = pins_s[3];

	pmr_energy_timer #(
		.TIMEOUT_CYC(ENERGY_TIMEOUT_CYC)
	) u_energy (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.ef(ef)
	);

	pmr_core_s st_ff;
	pmr_core_s nxt_st;

	// ----------------------------------------
	// Interrupt events
	// ----------------------------------------
	logic [7:1] ev;

	assign ev[7] = ef.rise;
	assign ev[6] = AUTONEG_DONE_I & ~st_ff.an_done_q;
	assign ev[5] = REMOTE_FAULT_I & ~st_ff.rfault_q;
	assign ev[4] = ~LINK_UP_I & st_ff.link_q;
	assign ev[3] = LP_ACK_I & ~st_ff.lp_ack_q;
	assign ev[2] = PD_FAULT_I;
	assign ev[1] = PAGE_RX_I;

	// ----------------------------------------
	// Register read view
	// ----------------------------------------
	function automatic logic [15:0] rd_word(input pmr_core_s s, input logic [4:0] ad,
		input logic energy, input logic pol);
		logic [15:0] w;
		w = 16'h0000;
		unique case (ad)
			`PMR_REG_EXPANSION: begin
				w[`PMR_EXP_PD_FAULT] = s.exp_pdf;
				w[`PMR_EXP_LP_NP] = LP_NEXT_PAGE_I;
				w[`PMR_EXP_PAGE_RX] = s.exp_page;
				w[`PMR_EXP_LP_AN] = LP_AUTONEG_I;
			end
			`PMR_REG_MODE_CS: begin
				w[`PMR_MCS_EDPD] = s.edpd;
				w[`PMR_MCS_ENERGY] = energy;
			end
			`PMR_REG_SPECIAL_MODES: begin
				w[7:5] = s.mode;
				w[4:0] = s.phy_management_address;
			end
			`PMR_REG_CROSSOVER: begin
				w[`PMR_XO_OVERRIDE] = s.xo_ovr;
				w[`PMR_XO_AUTO] = s.xo_auto;
				w[`PMR_XO_STATE] = s.xo_state;
				w[`PMR_XO_PLL_LOCK] = s.pll_lock;
				w[`PMR_XO_POLARITY] = pol;
			end
			`PMR_REG_IRQ_FLAGS: begin
				w[7:1] = s.isf;
			end
			`PMR_REG_IRQ_MASK: begin
				w[7:0] = s.imask;
			end
			default: begin
				w = 16'h0000;
			end
		endcase
		return w;
	endfunction

	// ----------------------------------------
	// Management frame engine and registers
	// ----------------------------------------
	logic mdc_rise;
	logic [11:0] hdr;

	assign mdc_rise = mdc_s & ~st_ff.mdc_prev;
	assign hdr = {st_ff.shreg[10:0], mdio_s};

	always_comb begin
		nxt_st = st_ff;
		nxt_st.mdc_prev = mdc_s;
		if (mdc_rise) begin
			unique case (st_ff.state)
				SMI_IDLE: begin
					if (mdio_s) begin
						if (st_ff.pre_cnt != `PMR_PREAMBLE_LEN) begin
							nxt_st.pre_cnt = st_ff.pre_cnt + 6'h01;
						end
					end else if (st_ff.pre_cnt == `PMR_PREAMBLE_LEN) begin
						nxt_st.state = SMI_START;
					end else begin
						nxt_st.pre_cnt = 6'h00;
					end
				end
				SMI_START: begin
					nxt_st.pre_cnt = 6'h00;
					nxt_st.bit_cnt = 5'h00;
					nxt_st.state = mdio_s ? SMI_HDR : SMI_IDLE;
				end
				SMI_HDR: begin
					nxt_st.shreg = {st_ff.shreg[14:0], mdio_s};
					nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
					if (st_ff.bit_cnt == 5'h0b) begin
						nxt_st.bit_cnt = 5'h00;
						nxt_st.regad = hdr[4:0];
						nxt_st.is_rd = (hdr[11:10] == `PMR_OP_READ);
						nxt_st.match = (hdr[9:5] == st_ff.phy_management_address);
						nxt_st.state = SMI_TA;
						if (hdr[11:10] != `PMR_OP_READ && hdr[11:10] != `PMR_OP_WRITE) begin
							nxt_st.state = SMI_IDLE;
						end
						if (hdr[11:10] == `PMR_OP_READ && hdr[9:5] == st_ff.phy_management_address) begin
							nxt_st.shreg = rd_word(st_ff, hdr[4:0], ef.flag,
								TENBASE_POLARITY_REVERSED_I);
							// Reading clears what it latched
							if (hdr[4:0] == `PMR_REG_EXPANSION) begin
								nxt_st.exp_pdf = 1'b0;
								nxt_st.exp_page = 1'b0;
							end
							if (hdr[4:0] == `PMR_REG_IRQ_FLAGS) begin
								nxt_st.isf = 7'h00;
							end
						end
					end
				end
				SMI_TA: begin
					nxt_st.bit_cnt = 5'h01;
					if (st_ff.bit_cnt == 5'h00) begin
						// Drive the second turnaround bit low
						nxt_st.mdio_oe = st_ff.is_rd & st_ff.match;
						nxt_st.mdio_o = 1'b0;
					end else begin
						nxt_st.bit_cnt = 5'h00;
						nxt_st.state = SMI_DATA;
						if (st_ff.is_rd) begin
							nxt_st.mdio_o = st_ff.shreg[15];
							nxt_st.shreg = {st_ff.shreg[14:0], 1'b0};
						end
					end
				end
				SMI_DATA: begin
					nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
					if (st_ff.is_rd) begin
						nxt_st.mdio_o = st_ff.shreg[15];
						nxt_st.shreg = {st_ff.shreg[14:0], 1'b0};
					end else begin
						nxt_st.shreg = {st_ff.shreg[14:0], mdio_s};
					end
					if (st_ff.bit_cnt == 5'h0f) begin
						nxt_st.state = SMI_IDLE;
						nxt_st.mdio_oe = 1'b0;
						nxt_st.mdio_o = 1'b0;
						if (!st_ff.is_rd && st_ff.match) begin
							unique case (st_ff.regad)
								`PMR_REG_MODE_CS: begin
									nxt_st.edpd = mdio_s ? st_ff.shreg[12] :
										st_ff.shreg[12];
								end
								`PMR_REG_SPECIAL_MODES: begin
									nxt_st.mode = st_ff.shreg[6:4];
									nxt_st.phy_management_address = {st_ff.shreg[3:0], mdio_s};
								end
								`PMR_REG_CROSSOVER: begin
									nxt_st.xo_ovr = st_ff.shreg[14];
									nxt_st.xo_auto = st_ff.shreg[13];
									nxt_st.xo_state = st_ff.shreg[12];
									nxt_st.pll_lock = st_ff.shreg[9];
								end
								`PMR_REG_IRQ_MASK: begin
									nxt_st.imask = {st_ff.shreg[6:0], mdio_s};
								end
								default: begin
									nxt_st.imask = st_ff.imask;
								end
							endcase
						end
					end
				end
				default: begin
					nxt_st.state = SMI_IDLE;
				end
			endcase
		end

		// Soft reset spares mode, address, PLL lock and energy flag
		if (SOFT_RST_I) begin
			nxt_st.edpd = 1'b0;
			nxt_st.xo_ovr = 1'b0;
			nxt_st.xo_auto = 1'b0;
			nxt_st.xo_state = 1'b0;
			nxt_st.imask = 8'h00;
			nxt_st.exp_pdf = 1'b0;
			nxt_st.exp_page = 1'b0;
			nxt_st.isf = 7'h00;
		end

		// Sets come last so an event in a clearing cycle survives
		nxt_st.exp_pdf = nxt_st.exp_pdf | PD_FAULT_I;
		nxt_st.exp_page = nxt_st.exp_page | PAGE_RX_I;
		nxt_st.isf = nxt_st.isf | ev;
		nxt_st.an_done_q = AUTONEG_DONE_I;
		nxt_st.rfault_q = REMOTE_FAULT_I;
		nxt_st.link_q = LINK_UP_I;
		nxt_st.lp_ack_q = LP_ACK_I;

		// ----------------------------------------
		// Derived controls
		// ----------------------------------------
		nxt_st.irq = |({nxt_st.isf, 1'b0} & nxt_st.imask);
		nxt_st.crs_tx = 1'b0;
		nxt_st.repeater = 1'b0;
		nxt_st.adv_def = 4'h0;
		unique case (nxt_st.mode)
			3'h0: nxt_st.ctrl_def = 4'h0;
			3'h1: nxt_st.ctrl_def = 4'h1;
			3'h2: begin
				nxt_st.ctrl_def = 4'h8;
				nxt_st.crs_tx = 1'b1;
			end
			3'h3: nxt_st.ctrl_def = 4'h9;
			3'h4: begin
				nxt_st.ctrl_def = 4'hc;
				nxt_st.adv_def = 4'h4;
				nxt_st.crs_tx = 1'b1;
			end
			3'h5: begin
				nxt_st.ctrl_def = 4'hc;
				nxt_st.adv_def = 4'h4;
				nxt_st.repeater = 1'b1;
			end
			// Reserved code: behaves as 10 Mb/s half duplex
			3'h6: nxt_st.ctrl_def = 4'h0;
			3'h7: begin
				nxt_st.ctrl_def = {RESOLVED_SPEED_100_I, 2'h2, RESOLVED_FULL_DUPLEX_I};
				nxt_st.adv_def = 4'hf;
			end
		endcase
		nxt_st.an_en = nxt_st.ctrl_def[2];

		// Manual crossover swap only when override set and auto off
		nxt_st.xo_auto_en = nxt_st.xo_ovr ? nxt_st.xo_auto : strap_s;
		nxt_st.xo_swap = nxt_st.xo_ovr & ~nxt_st.xo_auto & nxt_st.xo_state;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			st_ff <= '0;
			st_ff.state <= SMI_IDLE;
			st_ff.mode <= `PMR_MODE_RST;
			st_ff.phy_management_address <= `PMR_PHY_MANAGEMENT_ADDRESS_RST;
			st_ff.ctrl_def <= 4'h4;
			st_ff.adv_def <= 4'hf;
			st_ff.an_en <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign MDIO_O = st_ff.mdio_o;
	assign MDIO_OE_O = st_ff.mdio_oe;
	assign PHY_IRQ_O = st_ff.irq;
	assign ENERGY_DETECT_POWERDOWN_ENABLE_O = st_ff.edpd;
	assign ENERGY_PRESENT_FLAG_O = ef.flag;
	assign MODE_CTRL_DEFAULT_O = st_ff.ctrl_def;
	assign MODE_ADVERT_DEFAULT_O = st_ff.adv_def;
	assign AUTONEG_ENABLE_O = st_ff.an_en;
	assign CRS_ON_TRANSMIT_O = st_ff.crs_tx;
	assign REPEATER_MODE_O = st_ff.repeater;
	assign CROSSOVER_AUTO_ENABLE_O = st_ff.xo_auto_en;
	assign CROSSOVER_SWAP_O = st_ff.xo_swap;
	assign RX_PLL_REFERENCE_LOCK_O = st_ff.pll_lock;
endmodule

// [dv/pmr_phy_mode_regs_assertions.sv]
`timescale 1ns/1ps

module pmr_phy_mode_regs_assertions #(
	parameter int ENERGY_TIMEOUT_CYC = 64
) (
	// Clock and resets
	input logic SYS_CLK_I,
	input logic RST_I,
	input logic SOFT_RST_I,
	// Management link and line
	input logic MDC_I,
	input logic MDIO_O,
	input logic MDIO_OE_O,
	input logic LINE_ENERGY_I,
	// Status and control outputs
	input logic PHY_IRQ_O,
	input logic ENERGY_DETECT_POWERDOWN_ENABLE_O,
	input logic ENERGY_PRESENT_FLAG_O,
	input logic [3:0] MODE_CTRL_DEFAULT_O,
	input logic [3:0] MODE_ADVERT_DEFAULT_O,
	input logic AUTONEG_ENABLE_O,
	input logic CRS_ON_TRANSMIT_O,
	input logic REPEATER_MODE_O,
	input logic CROSSOVER_AUTO_ENABLE_O,
	input logic CROSSOVER_SWAP_O,
	input logic RX_PLL_REFERENCE_LOCK_O
);
	int quiet_cnt_ff;

	// Raw quiet count leads the synchronised one, so bounds carry margin
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I || LINE_ENERGY_I) begin
			quiet_cnt_ff <= 0;
		end else begin
			quiet_cnt_ff <= quiet_cnt_ff + 1;
		end
	end

	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (RST_I);

	sequence s_irq_idle;
		PHY_IRQ_O && !SOFT_RST_I && !MDC_I;
	endsequence
	sequence s_energy_steady;
		LINE_ENERGY_I [*6];
	endsequence

	chk_reset_values: assert property ($fell(RST_I) |->
		ENERGY_PRESENT_FLAG_O && !PHY_IRQ_O && !ENERGY_DETECT_POWERDOWN_ENABLE_O
		&& !RX_PLL_REFERENCE_LOCK_O && !MDIO_OE_O && MODE_ADVERT_DEFAULT_O == 4'hf)
		else $error("outputs wrong after reset");
	chk_an_ctrl_bit: assert property (AUTONEG_ENABLE_O == MODE_CTRL_DEFAULT_O[2])
		else $error("negotiation enable disagrees with control default");
	chk_crs_modes: assert property (CRS_ON_TRANSMIT_O |-> MODE_CTRL_DEFAULT_O[3:1] == 3'h4
		|| MODE_CTRL_DEFAULT_O == 4'hc) else $error("carrier on transmit in wrong mode");
	chk_repeater_mode: assert property (REPEATER_MODE_O |-> MODE_CTRL_DEFAULT_O == 4'hc
		&& !CRS_ON_TRANSMIT_O && MODE_ADVERT_DEFAULT_O == 4'h4)
		else $error("repeater mode defaults wrong");
	chk_swap_manual: assert property (CROSSOVER_SWAP_O |-> !CROSSOVER_AUTO_ENABLE_O)
		else $error("pair swap while automatic crossover on");
	chk_irq_held: assert property (s_irq_idle [*8] |=> PHY_IRQ_O)
		else $error("interrupt dropped without a management access");
	chk_ta_zero: assert property ($rose(MDIO_OE_O) |-> !MDIO_O)
		else $error("turnaround bit not zero");
	chk_energy_on: assert property (s_energy_steady |-> ENERGY_PRESENT_FLAG_O)
		else $error("energy flag low with line energy present");
	chk_energy_early: assert property ($fell(ENERGY_PRESENT_FLAG_O) |->
		quiet_cnt_ff >= ENERGY_TIMEOUT_CYC) else $error("energy flag fell too early");
	chk_energy_late: assert property (quiet_cnt_ff == ENERGY_TIMEOUT_CYC + 8 |->
		!ENERGY_PRESENT_FLAG_O) else $error("energy flag did not fall");
endmodule

// [dv/pmr_smi_station.sv]
`timescale 1ns/1ps
`include "pmr_consts.svh"

module pmr_smi_station (
	// Management link
	output logic mdc_o,
	output logic mdio_oe_o,
	output logic mdio_o,
	input logic mdio_i
);
	initial begin
		mdc_o = 1'b0;
		mdio_oe_o = 1'b0;
		mdio_o = 1'b1;
	end

	// Clock stands low between frames; data moves on the falling edge
	task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [63:0] bits;
		logic rd_op;
		bits = {32'hffff_ffff, 2'b01, op, pa, ra, 2'b10, wd};
		rd_op = (op == `PMR_OP_READ);
		rd = 16'h0;
		for (int i = 0; i < 64; i++) begin
			mdio_oe_o = !(rd_op && i >= 46);
			mdio_o = bits[63 - i];
			#62.5;
			mdc_o = 1'b1;
			if (rd_op && i >= 48) begin
				rd = {rd[14:0], mdio_i};
			end
			#62.5;
			mdc_o = 1'b0;
		end
		mdio_oe_o = 1'b0;
		#250;
	endtask
endmodule

// [dv/pmr_phy_mode_regs_tb.sv]
`timescale 1ns/1ps
`include "pmr_consts.svh"

module pmr_phy_mode_regs_tb;
	localparam int ENERGY_T = 64;
	logic clk, rst, srst, strap, energy, pdf, page, lpnp, lpan, an_done, rfault, link, ack;
	logic pol, spd, fdx, mdc, st_oe, st_d, mdio_w, dut_d, dut_oe, irq, edpd, eflag, aneg;
	logic crs, rep, xo_auto, xo_swap, pll;
	logic [3:0] ctrl, adv;
	logic [15:0] got, obs;
	logic [4:0] pa, npa;
	logic [7:0] msk;
	logic [2:0] md;
	logic [2:0] xo_tab [5] = '{3'b000, 3'b100, 3'b101, 3'b110, 3'b011};
	int seed = 32'h3fbe;
	int miscompares = 0;
	int n_tests = 0;

	// Pulled-up line when nobody drives
	assign mdio_w = dut_oe ? dut_d : (st_oe ? st_d : 1'b1);

	pmr_smi_station st_u (.mdc_o(mdc), .mdio_oe_o(st_oe), .mdio_o(st_d), .mdio_i(mdio_w));

	pmr_phy_mode_regs #(.ENERGY_TIMEOUT_CYC(ENERGY_T)) dut_u (
		.SYS_CLK_I(clk), .RST_I(rst), .SOFT_RST_I(srst), .MDC_I(mdc), .MDIO_I(mdio_w),
		.MDIO_O(dut_d), .MDIO_OE_O(dut_oe), .CROSSOVER_AUTO_STRAP_I(strap),
		.LINE_ENERGY_I(energy), .PD_FAULT_I(pdf), .PAGE_RX_I(page), .LP_NEXT_PAGE_I(lpnp),
		.LP_AUTONEG_I(lpan), .AUTONEG_DONE_I(an_done), .REMOTE_FAULT_I(rfault),
		.LINK_UP_I(link), .LP_ACK_I(ack), .TENBASE_POLARITY_REVERSED_I(pol),
		.RESOLVED_SPEED_100_I(spd), .RESOLVED_FULL_DUPLEX_I(fdx), .PHY_IRQ_O(irq),
		.ENERGY_DETECT_POWERDOWN_ENABLE_O(edpd), .ENERGY_PRESENT_FLAG_O(eflag),
		.MODE_CTRL_DEFAULT_O(ctrl), .MODE_ADVERT_DEFAULT_O(adv), .AUTONEG_ENABLE_O(aneg),
		.CRS_ON_TRANSMIT_O(crs), .REPEATER_MODE_O(rep), .CROSSOVER_AUTO_ENABLE_O(xo_auto),
		.CROSSOVER_SWAP_O(xo_swap), .RX_PLL_REFERENCE_LOCK_O(pll)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Frames end off-grid; realign so later stimulus lands just after an edge
	task automatic rd(input logic [4:0] ra, input logic [15:0] e);
		st_u.frame(`PMR_OP_READ, pa, ra, 16'h0, got);
		cyc(1);
		chk(got, e);
	endtask
	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		st_u.frame(`PMR_OP_WRITE, pa, ra, d, got);
		cyc(1);
	endtask
	function automatic logic [3:0] exp_ctrl(input logic [2:0] m);
		case (m)
			3'h0: exp_ctrl = 4'h0;
			3'h1: exp_ctrl = 4'h1;
			3'h2: exp_ctrl = 4'h8;
			3'h3: exp_ctrl = 4'h9;
			3'h7: exp_ctrl = {spd, 1'b1, 1'b0, fdx};
			default: exp_ctrl = 4'hc;
		endcase
	endfunction
	task automatic fire(input int k);
		case (k)
			7: begin
				energy = 1'b0;
				cyc(ENERGY_T + 12);
				chk({15'h0, eflag}, 16'h0);
				energy = 1'b1;
			end
			6: an_done = 1'b1;
			5: rfault = 1'b1;
			4: link = 1'b0;
			3: ack = 1'b1;
			2: pdf = 1'b1;
			default: page = 1'b1;
		endcase
		cyc(1);
		{pdf, page} = 2'h0;
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Clock, watchdog, main sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		cyc(95000);
		miscompares++;
		report_and_stop();
	end
	initial begin
		rst = 1'b1;
		srst = 1'b0;
		{strap, pol, spd, fdx, lpnp, lpan} = 6'($random(seed));
		{energy, pdf, page, an_done, rfault, link, ack} = 7'b1000010;
		pa = `PMR_PHY_MANAGEMENT_ADDRESS_RST;
		cyc(20);
		rst = 1'b0;
		cyc(3);
		obs = {ctrl, adv, aneg, eflag, irq, edpd, pll, xo_auto, xo_swap, crs};
		chk(obs, {exp_ctrl(3'h7), 9'h1f8, strap, 2'h0});
		rd(`PMR_REG_EXPANSION, {12'h0, lpnp, 2'h0, lpan});
		rd(`PMR_REG_MODE_CS, 16'h0002);
		rd(`PMR_REG_SPECIAL_MODES, 16'h00e1);
		rd(`PMR_REG_CROSSOVER, {11'h0, pol, 4'h0});
		rd(`PMR_REG_IRQ_FLAGS, 16'h0);
		rd(`PMR_REG_IRQ_MASK, 16'h0);
		rd(5'h07, 16'h0);
		for (int m = 0; m < 8; m++) begin
			md = 3'(m);
			{spd, fdx} = 2'($random(seed));
			if (md != 3'h6) begin
				wr(`PMR_REG_SPECIAL_MODES, {8'h0, md, pa});
				rd(`PMR_REG_SPECIAL_MODES, {8'h0, md, pa});
				chk({12'h0, ctrl}, {12'h0, exp_ctrl(md)});
				obs = {13'h0, aneg, crs, rep};
				chk(obs, {13'h0, md[2], md == 3'h2 || md == 3'h4, md == 3'h5});
				if (md[2]) begin
					chk({12'h0, adv}, {12'h0, md == 3'h7 ? 4'hf : 4'h4});
				end
			end
		end
		npa = 5'h10 | 5'($random(seed));
		wr(`PMR_REG_SPECIAL_MODES, {8'h0, 3'h4, npa});
		rd(`PMR_REG_SPECIAL_MODES, 16'hffff);
		pa = npa;
		rd(`PMR_REG_SPECIAL_MODES, {8'h0, 3'h4, npa});
		st_u.frame(2'h3, pa, `PMR_REG_MODE_CS, 16'h2000, got);
		rd(`PMR_REG_MODE_CS, 16'h0002);
		wr(`PMR_REG_MODE_CS, 16'h2000);
		wr(`PMR_REG_CROSSOVER, 16'ha400);
		chk({15'h0, edpd}, 16'h1);
		rd(`PMR_REG_MODE_CS, 16'h2002);
		srst = 1'b1;
		cyc(1);
		srst = 1'b0;
		cyc(3);
		rd(`PMR_REG_MODE_CS, 16'h0002);
		rd(`PMR_REG_SPECIAL_MODES, {8'h0, 3'h4, pa});
		rd(`PMR_REG_CROSSOVER, 16'h0400 | {11'h0, pol, 4'h0});
		for (int i = 0; i < 5; i++) begin
			{strap, pol} = 2'($random(seed));
			wr(`PMR_REG_CROSSOVER, {xo_tab[i], 13'h0400});
			cyc(4);
			obs = {13'h0, pll, xo_auto, xo_swap};
			md = {1'b1, xo_tab[i][2] ? xo_tab[i][1] : strap, xo_tab[i] == 3'b101};
			chk(obs, {13'h0, md});
			rd(`PMR_REG_CROSSOVER, {xo_tab[i], 13'h0400 | {8'h0, pol, 4'h0}});
		end
		for (int k = 7; k >= 1; k--) begin
			msk = 8'($random(seed));
			wr(`PMR_REG_IRQ_MASK, {8'h0, msk});
			cyc(2);
			fire(k);
			cyc(8);
			chk({15'h0, irq}, {15'h0, msk[k]});
			rd(`PMR_REG_IRQ_FLAGS, 16'h1 << k);
			{an_done, rfault, ack, link} = 4'b0001;
			cyc(4);
			chk({15'h0, irq}, 16'h0);
			rd(`PMR_REG_IRQ_FLAGS, 16'h0);
		end
		rd(`PMR_REG_EXPANSION, {11'h0, 1'b1, lpnp, 2'h1, lpan});
		rd(`PMR_REG_EXPANSION, {12'h0, lpnp, 2'h0, lpan});
		energy = 1'b0;
		cyc(ENERGY_T + 12);
		rst = 1'b1;
		cyc(2);
		rst = 1'b0;
		cyc(3);
		chk({15'h0, eflag}, 16'h1);
		pa = `PMR_PHY_MANAGEMENT_ADDRESS_RST;
		rd(`PMR_REG_SPECIAL_MODES, 16'h00e1);
		report_and_stop();
	end
endmodule

bind pmr_phy_mode_regs pmr_phy_mode_regs_assertions #(.ENERGY_TIMEOUT_CYC(ENERGY_TIMEOUT_CYC))
	chk_u (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .SOFT_RST_I(SOFT_RST_I), .MDC_I(MDC_I),
	.MDIO_O(MDIO_O), .MDIO_OE_O(MDIO_OE_O), .LINE_ENERGY_I(LINE_ENERGY_I),
	.PHY_IRQ_O(PHY_IRQ_O), .ENERGY_DETECT_POWERDOWN_ENABLE_O(ENERGY_DETECT_POWERDOWN_ENABLE_O),
	.ENERGY_PRESENT_FLAG_O(ENERGY_PRESENT_FLAG_O), .MODE_CTRL_DEFAULT_O(MODE_CTRL_DEFAULT_O),
	.MODE_ADVERT_DEFAULT_O(MODE_ADVERT_DEFAULT_O), .AUTONEG_ENABLE_O(AUTONEG_ENABLE_O),
	.CRS_ON_TRANSMIT_O(CRS_ON_TRANSMIT_O), .REPEATER_MODE_O(REPEATER_MODE_O),
	.CROSSOVER_AUTO_ENABLE_O(CROSSOVER_AUTO_ENABLE_O), .CROSSOVER_SWAP_O(CROSSOVER_SWAP_O),
	.RX_PLL_REFERENCE_LOCK_O(RX_PLL_REFERENCE_LOCK_O));
